// ---- verilog/meb_pkg.sv ----
package meb_pkg;

    // Address windows of the external bus
    localparam logic [15:0] MEB_WIN_LO    = 16'h1000;
    localparam logic [15:0] MEB_WIN_HI    = 16'h11ff;
    localparam logic [7:0]  MEB_CODEC_HI  = 8'h10;
    localparam logic [7:0]  MEB_EEPROM_HI = 8'h11;

    // Cycle plan of one external access (six cycles, index 0..5)
    localparam int          MEB_ACC_CYCLES = 6;
    localparam logic [2:0]  MEB_PH_ALE     = 3'h0;
    localparam logic [2:0]  MEB_PH_HOLD    = 3'h1;
    localparam logic [2:0]  MEB_PH_STB_ON  = 3'h2;
    localparam logic [2:0]  MEB_PH_STB_OFF = 3'h4;
    localparam logic [2:0]  MEB_PH_LAST    = 3'h5;

    // Reset values
    localparam logic [7:0]  MEB_BUS_RST = 8'h00;

    typedef enum logic [1:0] {MEB_IDLE, MEB_ADDR, MEB_DATA, MEB_DONE} meb_state_e;

    // Request from the internal processor side
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } meb_req_s;

    // Outward pin group
    typedef struct packed {
        logic       ale;
        logic       wr_n;
        logic       rd_n;
        logic       codec_select_n;
        logic       eeprom_select_n;
        logic [7:0] bus_out;
        logic       bus_oe;
    } meb_pins_s;

endpackage

// ---- verilog/meb_sync.sv ----
`timescale 1ns/100ps
// Two-stage synchroniser for pin inputs; stage one feeds stage two only
module meb_sync
    import meb_pkg::*;
#(
    parameter int W = 1
)
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } meb_sync_s;

    meb_sync_s st_ff;
    meb_sync_s nxt_st;

    // Shift pin level through two stages
    always_comb
    begin
        nxt_st    = st_ff;
        nxt_st.s1 = d;
        nxt_st.s2 = st_ff.s1;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign q = st_ff.s2;

endmodule

// ---- verilog/meb_bus.sv ----
`timescale 1ns/100ps
//
// Contract
// - Codec select goes low during an external access to 1000H..10FFH.
// - EEPROM select goes low during an external access to 1100H..11FFH.
// - Accesses to 1000H..11FFH use the 8-bit muxed bus, address first then data.
// - On a write, data is valid on the bus when the write strobe rises.
// - A high on the master reset input holds the block in reset.
// - The latch strobe idles low and the address is valid at its falling edge.
// - Each external access lasts six clock cycles.
//
module meb_bus
    import meb_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire meb_req_s    req,
    output logic             req_ready,
    output logic             rsp_valid,
    output logic [7:0]       rsp_rdata,
    output logic             rsp_miss,
    input  wire logic [7:0]  muxed_bus_in,
    output logic [7:0]       muxed_bus_out,
    output logic             muxed_bus_oe,
    output logic             ale,
    output logic             wr_n,
    output logic             rd_n,
    output logic             codec_select_n,
    output logic             eeprom_select_n
);

    // Whole state of the block; one comb copy, one register
    typedef struct packed {
        meb_state_e  state;
        logic [2:0]  phase;
        logic        write;
        logic [15:0] addr;
        logic [7:0]  wdata;
        meb_pins_s   pins;
        logic        ready;
        logic        done;
        logic [7:0]  rdata;
        logic        miss;
    } meb_st_s;

    meb_st_s    st_ff;
    meb_st_s    nxt_st;
    logic [7:0] bus_in_sync;

    // Returns 1 for an address inside the muxed bus window; anything else
    // gets no bus cycle at all and is answered as a miss
    function automatic logic in_window(input logic [15:0] a);
        in_window = (a >= MEB_WIN_LO) && (a <= MEB_WIN_HI);
    endfunction

    // Next phase index; both bus states step the same counter
    function automatic logic [2:0] phase_step(input logic [2:0] p);
        phase_step = p + 3'h1;
    endfunction

    // Pin levels with no access running; reset and the end of an access
    // both take them from here so the two cannot drift apart
    function automatic meb_pins_s idle_pins();
        idle_pins                 = '0;
        idle_pins.wr_n            = 1'b1;
        idle_pins.rd_n            = 1'b1;
        idle_pins.codec_select_n  = 1'b1;
        idle_pins.eeprom_select_n = 1'b1;
        idle_pins.bus_out         = MEB_BUS_RST;
    endfunction

    // Bus data comes from outside the clock domain, so synchronise it
    meb_sync #(
        .W (8)
    ) u_sync (
        .clk (clk),
        .rst (rst),
        .d   (muxed_bus_in),
        .q   (bus_in_sync)
    );

    // Access sequencer. Pin plan of a window access, by clock cycle after
    // the edge that takes the request:
    //   1      latch strobe high, address byte out, one select low
    //   2      latch strobe low; address still held so the latch closes on it
    //   3..5   write byte out with write strobe low, or bus released with
    //          read strobe low so the peripheral can turn it around
    //   6      strobe high again; data and select still held
    //   7      bus released, select high, answer pulse with read byte
    //   8      ready for the next request
    // A miss skips the bus entirely: answer in cycle 1, ready in cycle 2.
    // The select is low for cycles 1..6, the six bus cycles of an access.
    // The read byte is the bus level of cycle 4, which reaches the logic
    // through both sync stages in cycle 6. The price of synchronising is
    // that the peripheral must have its byte out one cycle before the
    // strobe rises, not just at the rise.
    always_comb
    begin
        nxt_st      = st_ff;
        nxt_st.done = 1'b0;
        nxt_st.miss = 1'b0;
        case (st_ff.state)
            MEB_IDLE:
            begin
                nxt_st.ready = 1'b1;
                // Request looked at only while ready stands; hold it till then
                if (req.valid && st_ff.ready)
                begin
                    nxt_st.ready = 1'b0;
                    if (in_window(req.addr))
                    begin
                        nxt_st.state = MEB_ADDR;
                        nxt_st.phase = MEB_PH_ALE;
                        nxt_st.write = req.write;
                        nxt_st.addr  = req.addr;
                        nxt_st.wdata = req.wdata;
                        // Address out, latch strobe high, selects decoded
                        nxt_st.pins.bus_out = req.addr[7:0];
                        nxt_st.pins.bus_oe  = 1'b1;
                        nxt_st.pins.ale     = 1'b1;
                        // Upper byte picks exactly one select
                        nxt_st.pins.codec_select_n  =
                            (req.addr[15:8] != MEB_CODEC_HI);
                        nxt_st.pins.eeprom_select_n =
                            (req.addr[15:8] != MEB_EEPROM_HI);
                    end
                    else
                    begin
                        // Out of window: no bus cycle, flag a miss
                        nxt_st.state = MEB_DONE;
                        nxt_st.miss  = 1'b1;
                        nxt_st.done  = 1'b1;
                        nxt_st.rdata = MEB_BUS_RST;
                    end
                end
            end
            MEB_ADDR:
            begin
                nxt_st.phase = phase_step(st_ff.phase);
                // Address held while the strobe falls
                if (st_ff.phase == MEB_PH_ALE)
                    nxt_st.pins.ale = 1'b0;
                // Second cycle: switch the bus from address to data, or let go
                if (st_ff.phase == MEB_PH_HOLD)
                begin
                    nxt_st.state = MEB_DATA;
                    if (st_ff.write)
                    begin
                        nxt_st.pins.bus_out = st_ff.wdata;
                        nxt_st.pins.wr_n    = 1'b0;
                    end
                    else
                    begin
                        nxt_st.pins.bus_oe = 1'b0;
                        nxt_st.pins.rd_n   = 1'b0;
                    end
                end
            end
            MEB_DATA:
            begin
                nxt_st.phase = phase_step(st_ff.phase);
                // Strobe rises with data still held steady
                if (st_ff.phase == MEB_PH_STB_OFF)
                begin
                    nxt_st.pins.wr_n = 1'b1;
                    nxt_st.pins.rd_n = 1'b1;
                end
                if (st_ff.phase == MEB_PH_LAST)
                begin
                    nxt_st.state = MEB_DONE;
                    nxt_st.done  = 1'b1;
                    // Bus level of cycle 4, one cycle before the strobe rise
                    nxt_st.rdata = st_ff.write ? st_ff.wdata : bus_in_sync;
                    nxt_st.pins  = idle_pins();
                end
            end
            MEB_DONE:
            begin
                // One quiet cycle, the one with the answer, before ready rises again
                nxt_st.state = MEB_IDLE;
                nxt_st.ready = 1'b1;
            end
            default:
            begin
                nxt_st.state = MEB_IDLE;
            end
        endcase
    end

    // Synchronous active-high reset idles every pin
    // Level sensitive: a held reset keeps the pins idle and ready low
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_ff       <= '0;
            st_ff.state <= MEB_IDLE;
            st_ff.pins  <= idle_pins();
        end
        else
            st_ff <= nxt_st;
    end

    // All outputs come straight from state flops, so no pin ever
    // shows a combinational glitch from the sequencer
    assign req_ready       = st_ff.ready;
    assign rsp_valid       = st_ff.done;
    assign rsp_rdata       = st_ff.rdata;
    assign rsp_miss        = st_ff.miss;
    assign muxed_bus_out   = st_ff.pins.bus_out;
    assign muxed_bus_oe    = st_ff.pins.bus_oe;
    assign ale             = st_ff.pins.ale;
    assign wr_n            = st_ff.pins.wr_n;
    assign rd_n            = st_ff.pins.rd_n;
    assign codec_select_n  = st_ff.pins.codec_select_n;
    assign eeprom_select_n = st_ff.pins.eeprom_select_n;

endmodule

// ---- dv/meb_bus_sva.sv ----
`timescale 1ns/100ps
// Pin timing watcher for the external bus
module meb_bus_sva
    import meb_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst,
    input wire meb_req_s   req,
    input wire logic       req_ready,
    input wire logic       rsp_valid,
    input wire logic [7:0] muxed_bus_out,
    input wire logic       muxed_bus_oe,
    input wire logic       ale,
    input wire logic       wr_n,
    input wire logic       rd_n,
    input wire logic       codec_select_n,
    input wire logic       eeprom_select_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Taken request and its decoded window
    wire tk  = req.valid && req_ready;
    wire cod = req.addr[15:8] == MEB_CODEC_HI;
    wire hit = cod || req.addr[15:8] == MEB_EEPROM_HI;
    // Strobe low three cycles; a level low six cycles then high
    sequence pulse_s(s); !s [*3] ##1 s; endsequence
    sequence six_s(s); !s [*6] ##1 s; endsequence
    codec_sel_a: assert property (tk && cod |=> six_s(codec_select_n))
        else $error("codec select wrong");
    eeprom_sel_a: assert property (tk && hit && !cod |=> six_s(eeprom_select_n))
        else $error("eeprom select wrong");
    acc_len_a: assert property (tk && hit |=> six_s(rsp_valid))
        else $error("access length wrong");
    addr_phase_a: assert property (tk && hit |=> ale && muxed_bus_oe
        && muxed_bus_out == $past(req.addr[7:0]) ##1 !ale) else $error("address phase wrong");
    wr_data_a: assert property ($fell(wr_n) |-> pulse_s(wr_n)
        ##0 muxed_bus_oe && $stable(muxed_bus_out)) else $error("write data wrong");
    rd_turn_a: assert property ($fell(rd_n) |-> !muxed_bus_oe
        ##0 pulse_s(rd_n) ##0 !muxed_bus_oe) else $error("read turnaround wrong");
    sel_excl_a: assert property (codec_select_n || eeprom_select_n)
        else $error("both selects low");
    rst_idle_a: assert property (disable iff (1'b0) rst |=> !ale && wr_n && rd_n
        && codec_select_n && eeprom_select_n && !muxed_bus_oe) else $error("reset not idle");
endmodule
bind meb_bus meb_bus_sva u_sva (.clk(clk), .rst(rst), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .muxed_bus_out(muxed_bus_out), .muxed_bus_oe(muxed_bus_oe),
    .ale(ale), .wr_n(wr_n), .rd_n(rd_n), .codec_select_n(codec_select_n),
    .eeprom_select_n(eeprom_select_n));

// ---- dv/meb_periph.sv ----
`timescale 1ns/100ps
// Codec and EEPROM pair, 256 bytes each, behind a shared address latch
module meb_periph
(
    input  wire logic       clk,
    input  wire logic [7:0] bus_out,
    input  wire logic       ale,
    input  wire logic       wr_n,
    input  wire logic       rd_n,
    input  wire logic       cs_c_n,
    input  wire logic       cs_e_n,
    output logic      [7:0] bus_drv
);
    logic [7:0] mem [512];
    logic [7:0] adr_ff, last_ff;
    logic       wr_ff;
    wire        sel = !(cs_c_n && cs_e_n);
    initial for (int i = 0; i < 512; i++) mem[i] = 8'(i * 3);
    // Latch follows the bus while the strobe is high store on write rise
    always @(posedge clk)
    begin
        if (ale) adr_ff <= bus_out;
        wr_ff <= wr_n;
        if (wr_n && !wr_ff && sel) mem[{cs_c_n, adr_ff}] <= bus_out;
        last_ff <= bus_drv;
    end
    // Drives only while read strobe low; else toggles so stale data never looks valid
    assign bus_drv = (!rd_n && sel) ? mem[{cs_c_n, adr_ff}] : ~last_ff;
endmodule

// ---- dv/meb_bus_test.sv ----
`timescale 1ns/100ps
module meb_bus_test
    import meb_pkg::*;
;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    meb_req_s   req = '0;
    logic       rdy, vld, miss, oe, ale, wr_n, rd_n, cs_c_n, cs_e_n;
    logic [7:0] rdata, bout, bdrv, ref_m [512];
    logic [15:0] corner [6] = '{16'h0fff, 16'h1000, 16'h10ff, 16'h1100, 16'h11ff, 16'h1200};
    int         n_mismatch = 0, checked = 0, cyc = 0;
    integer     seed = 32'hc5bedac0;
    // Wire level: block drive wins, else whatever the partner puts out
    wire [7:0]  bin = oe ? bout : bdrv;
    meb_bus uut (.clk(clk), .rst(rst), .req(req), .req_ready(rdy), .rsp_valid(vld),
        .rsp_rdata(rdata), .rsp_miss(miss), .muxed_bus_in(bin), .muxed_bus_out(bout),
        .muxed_bus_oe(oe), .ale(ale), .wr_n(wr_n), .rd_n(rd_n),
        .codec_select_n(cs_c_n), .eeprom_select_n(cs_e_n));
    meb_periph peer (.clk(clk), .bus_out(bout), .ale(ale), .wr_n(wr_n), .rd_n(rd_n),
        .cs_c_n(cs_c_n), .cs_e_n(cs_e_n), .bus_drv(bdrv));
    initial forever #50 clk = ~clk;
    // Hang guard, well above the thousand or so cycles the run needs
    always @(posedge clk)
        if (++cyc == 8000)
        begin
            n_mismatch++;
            finish_test();
        end
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One access; expectation from the window and the shadow memory
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
        int n;
        logic hit;
        logic [7:0] e;
        hit = a inside {[MEB_WIN_LO:MEB_WIN_HI]};
        e = !hit ? 8'h00 : w ? d : ref_m[a[8:0]];
        if (hit && w) ref_m[a[8:0]] = d;
        @(posedge clk);
        req <= '{1'b1, w, a, d};
        n = 0;
        do @(posedge clk); while (rdy !== 1'b1 && ++n < 40);
        req.valid <= 1'b0;
        n = 0;
        do @(negedge clk); while (vld !== 1'b1 && ++n < 40);
        // Falling edges passed before the answer: six bus cycles, none for a miss
        chk("latency", 8'(n), hit ? 8'(MEB_ACC_CYCLES) : 8'h00);
        chk("rdata", rdata, e);
        chk("miss", 8'(miss), 8'(!hit));
    endtask
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        for (int i = 0; i < 512; i++) ref_m[i] = 8'(i * 3);
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        chk("idle", {ale, wr_n, rd_n, cs_c_n, cs_e_n, oe, 2'b00}, 8'h78);
        // Window edges, written then read back so a misplaced edge or one select for both windows shows
        foreach (corner[i]) acc(1'b1, corner[i], 8'(i) ^ 8'h3c);
        foreach (corner[i]) acc(1'b0, corner[i], 8'h00);
        repeat (150) acc(1'($random(seed)), 16'h0f80 + 16'({$random(seed)} % 768),
            8'($random(seed)));
        // Reset in mid-read must drop every strobe and select
        @(posedge clk);
        req <= '{1'b1, 1'b0, 16'h1080, 8'h00};
        repeat (4) @(posedge clk);
        req.valid <= 1'b0;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        chk("reset idle", {ale, wr_n, rd_n, cs_c_n, cs_e_n, oe, 2'b00}, 8'h78);
        acc(1'b0, 16'h1080, 8'h00);
        finish_test();
    end
endmodule
